// File: rtl/omp_addr_gen.sv
`include "omp_map.svh"

module omp_addr_gen (
    omp_exec_if.agen ifc
);

    always_comb begin
        ifc.indexed = 1'b0;
        if (ifc.a_bit) begin
            ifc.addr = {ifc.bank_sel, ifc.f};
        end else if (ifc.ext_en && ifc.f <= `OMP_ILO_MAX) begin
            // Wraps at the top of data space, as the pointer does
            ifc.addr    = ifc.ptr2 + {4'h0, ifc.f};
            ifc.indexed = 1'b1;
        end else if (ifc.f < `OMP_ACCESS_SPLIT) begin
            ifc.addr = {4'h0, ifc.f};
        end else begin
            ifc.addr = {`OMP_SFR_PAGE, ifc.f};
        end
    end

endmodule

// File: rtl/omp_alu.sv
module omp_alu (
    omp_exec_if.alu ifc
);

    always_comb begin
        if (ifc.op == omp_pkg::OP_IOR) begin
            ifc.result = ifc.acc | ifc.operand;
        end else begin
            ifc.result = ifc.operand;
        end
        ifc.neg  = ifc.result[7];
        ifc.zero = (ifc.result == 8'h00);
    end

endmodule

// File: rtl/omp_core_exec.sv
// Behaviour
// - Opcode 000100 with d, a and 8-bit address ORs acc with register.
// - For OR and copy, d=0 writes the accumulator, d=1 the register.
// - a=0 maps into the access bank, a=1 prefixes the bank select reg.
// - Extended set on and a=0: f up to 5Fh uses indexed literal offset.
// - Pointer load puts a 12-bit literal in pointer 0, 1 or 2, no flags.
// - Pointer load: two words and cycles, high part first, low byte last.
// - Opcode 010100 with d, a and address copies the register to dest.
// - Single-register copy reaches any byte of selected 256-byte bank.
// - Two-word copy: 1100 plus source, 1111 plus dest, flags untouched.
// - Two-word copy source and dest each span 000h to FFFh.
`include "omp_map.svh"

module omp_core_exec (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Data memory, one cycle read latency
    output logic [11:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    output logic             mem_re,
    output logic             mem_we,
    input  wire logic [7:0]  mem_rdata
);

    ////////////////////////////////////////////////////////////////////////
    omp_pkg::omp_regs_s r;
    omp_pkg::omp_regs_s n;
    omp_pkg::omp_op_e   opc;
    logic               wr_instr;
    logic               size_unused;

    omp_exec_if ifc ();

    omp_addr_gen u_agen (
        .ifc (ifc.agen)
    );

    omp_alu u_alu (
        .ifc (ifc.alu)
    );

    assign ifc.f       = r.ir[7:0];
    assign ifc.a_bit   = r.ir[`OMP_BIT_A];
    assign ifc.bank_sel = r.bank_sel;
    assign ifc.ext_en  = r.ext_en;
    assign ifc.ptr2    = r.ptr[2];
    assign ifc.op      = r.op;
    assign ifc.acc     = r.acc;
    assign ifc.operand = mem_rdata;

    // Only word transfers are issued; size is not checked
    assign size_unused = |hsize;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] reg_read(input omp_pkg::omp_regs_s s);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (s.bus_hit) begin
            case (s.bus_addr)
                `OMP_OFS_INSTR: v[15:0] = s.ir;
                `OMP_OFS_ACC:   v[7:0]  = s.acc;
                `OMP_OFS_BANK:  v[3:0]  = s.bank_sel;
                `OMP_OFS_FLAGS: begin
                    v[`OMP_FLAG_Z] = s.fz;
                    v[`OMP_FLAG_N] = s.fn;
                end
                `OMP_OFS_CTRL:  v[`OMP_CTRL_EXT] = s.ext_en;
                `OMP_OFS_STATE: begin
                    v[`OMP_STATE_BUSY] = (s.st != omp_pkg::ST_IDLE) &&
                                         (s.st != omp_pkg::ST_WAIT2);
                    v[`OMP_STATE_WAIT2] = (s.st == omp_pkg::ST_WAIT2);
                    v[`OMP_STATE_IDX]   = s.indexed;
                end
                `OMP_OFS_PTR0:  v[11:0] = s.ptr[0];
                `OMP_OFS_PTR1:  v[11:0] = s.ptr[1];
                `OMP_OFS_PTR2:  v[11:0] = s.ptr[2];
                default:        v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction

    // Byte ops share the read, process and write-back path
    function automatic logic byte_op(input omp_pkg::omp_op_e o);
        return (o == omp_pkg::OP_IOR) || (o == omp_pkg::OP_MOV);
    endfunction

    // Ops that park in WAIT2 for their second word
    function automatic logic two_word_op(input omp_pkg::omp_op_e o);
        return (o == omp_pkg::OP_PTR_LOAD) || (o == omp_pkg::OP_COPY2);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n        = r;
        n.mem_re = 1'b0;
        n.mem_we = 1'b0;
        n.hresp  = 1'b0;
        opc      = r.second ? r.op : omp_pkg::classify(r.ir);
        wr_instr = 1'b0;

        // Bus data phase: reads take one wait state so hrdata is a flop
        if (r.rd_pend) begin
            n.hrdata  = reg_read(r);
            n.hready  = 1'b1;
            n.rd_pend = 1'b0;
        end
        if (r.wr_pend) begin
            n.wr_pend = 1'b0;
            if (r.bus_hit) begin
                case (r.bus_addr)
                    `OMP_OFS_INSTR: wr_instr = 1'b1;
                    `OMP_OFS_ACC:   n.acc = hwdata[7:0];
                    `OMP_OFS_BANK:  n.bank_sel = hwdata[3:0];
                    `OMP_OFS_FLAGS: begin
                        n.fz = hwdata[`OMP_FLAG_Z];
                        n.fn = hwdata[`OMP_FLAG_N];
                    end
                    `OMP_OFS_CTRL:  n.ext_en = hwdata[`OMP_CTRL_EXT];
                    `OMP_OFS_PTR0:  n.ptr[0] = hwdata[11:0];
                    `OMP_OFS_PTR1:  n.ptr[1] = hwdata[11:0];
                    `OMP_OFS_PTR2:  n.ptr[2] = hwdata[11:0];
                    default:        n.wr_pend = 1'b0;
                endcase
            end
        end

        // Bus address phase
        if (hsel && hready && htrans[1]) begin
            n.bus_addr = haddr[7:0];
            n.bus_hit  = (haddr[31:8] == 24'h00_0000);
            n.wr_pend  = hwrite;
            n.rd_pend  = !hwrite;
            n.hready   = hwrite;
        end

        // Sequencer, one hclk per phase
        unique case (r.st)
            omp_pkg::ST_IDLE, omp_pkg::ST_WAIT2: begin
                // Words written while busy are dropped
                if (wr_instr) begin
                    n.ir = hwdata[15:0];
                    n.st = omp_pkg::ST_Q1;
                    n.second = (r.st == omp_pkg::ST_WAIT2) &&
                               (hwdata[15:12] == `OMP_OPC_SECOND);
                end
            end
            omp_pkg::ST_Q1: begin
                // Decode
                n.op = opc;
                if (opc == omp_pkg::OP_NONE) begin
                    n.st = omp_pkg::ST_IDLE;
                end else begin
                    n.st = omp_pkg::ST_Q2;
                    if (!r.second && byte_op(opc)) begin
                        n.mem_re   = 1'b1;
                        n.mem_addr = ifc.addr;
                        n.indexed  = ifc.indexed;
                        n.dst      = r.ir[`OMP_BIT_D];
                    end
                    if (!r.second && opc == omp_pkg::OP_COPY2) begin
                        n.mem_re   = 1'b1;
                        n.mem_addr = r.ir[11:0];
                    end
                    if (!r.second && opc == omp_pkg::OP_PTR_LOAD) begin
                        n.psel = r.ir[5:4];
                    end
                end
            end
            omp_pkg::ST_Q2: begin
                // Memory read in flight
                n.st = omp_pkg::ST_Q3;
            end
            omp_pkg::ST_Q3: begin
                // Process
                n.st = omp_pkg::ST_Q4;
                if (!r.second && byte_op(r.op)) begin
                    n.data    = ifc.result;
                    n.fn_pend = ifc.neg;
                    n.fz_pend = ifc.zero;
                    if (r.dst) begin
                        n.mem_we    = 1'b1;
                        n.mem_wdata = ifc.result;
                    end
                end
                if (r.op == omp_pkg::OP_COPY2) begin
                    if (!r.second) begin
                        n.data = mem_rdata;
                    end else begin
                        // Caller keeps PC and stack bytes out of reach
                        n.mem_we    = 1'b1;
                        n.mem_addr  = r.ir[11:0];
                        n.mem_wdata = r.data;
                    end
                end
            end
            omp_pkg::ST_Q4: begin
                // Write back
                n.st = omp_pkg::ST_IDLE;
                if (byte_op(r.op)) begin
                    if (!r.dst) begin
                        n.acc = r.data;
                    end
                    n.fn = r.fn_pend;
                    n.fz = r.fz_pend;
                end
                if (r.op == omp_pkg::OP_PTR_LOAD) begin
                    if (!r.second) begin
                        n.ptr[r.psel][11:8] = r.ir[3:0];
                    end else begin
                        n.ptr[r.psel][7:0] = r.ir[7:0];
                    end
                end
                if (two_word_op(r.op) && !r.second) begin
                    n.st = omp_pkg::ST_WAIT2;
                end
            end
            default: begin
                n.st = omp_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r           <= '0;
            r.st        <= omp_pkg::ST_IDLE;
            r.op        <= omp_pkg::OP_NONE;
            r.acc       <= `OMP_RST_ACC;
            r.bank_sel  <= `OMP_RST_BANK;
            r.ptr[0]    <= `OMP_RST_PTR;
            r.ptr[1]    <= `OMP_RST_PTR;
            r.ptr[2]    <= `OMP_RST_PTR;
            r.hready    <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign hreadyout = r.hready;
    assign hresp     = r.hresp;
    assign hrdata    = r.hrdata;
    assign mem_addr  = r.mem_addr;
    assign mem_wdata = r.mem_wdata;
    assign mem_re    = r.mem_re;
    assign mem_we    = r.mem_we;

endmodule

// File: rtl/omp_exec_if.sv
interface omp_exec_if;
    // Address generation
    logic [7:0]       f;
    logic             a_bit;
    logic [3:0]       bank_sel;
    logic             ext_en;
    logic [11:0]      ptr2;
    logic [11:0]      addr;
    logic             indexed;
    // Data path
    omp_pkg::omp_op_e op;
    logic [7:0]       acc;
    logic [7:0]       operand;
    logic [7:0]       result;
    logic             neg;
    logic             zero;

    modport core (output f, a_bit, bank_sel, ext_en, ptr2, op, acc, operand,
                  input addr, indexed, result, neg, zero);
    modport agen (input f, a_bit, bank_sel, ext_en, ptr2,
                  output addr, indexed);
    modport alu  (input op, acc, operand,
                  output result, neg, zero);
endinterface

// File: rtl/omp_map.svh
`ifndef OMP_MAP_SVH
`define OMP_MAP_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OMP_OFS_INSTR       8'h00
`define OMP_OFS_ACC         8'h04
`define OMP_OFS_BANK        8'h08
`define OMP_OFS_FLAGS       8'h0C
`define OMP_OFS_CTRL        8'h10
`define OMP_OFS_STATE       8'h14
`define OMP_OFS_PTR0        8'h18
`define OMP_OFS_PTR1        8'h1C
`define OMP_OFS_PTR2        8'h20

////////////////////////////////////////////////////////////////////////////
// Field positions
`define OMP_FLAG_Z          0
`define OMP_FLAG_N          1
`define OMP_CTRL_EXT        0
`define OMP_STATE_BUSY      0
`define OMP_STATE_WAIT2     1
`define OMP_STATE_IDX       2
`define OMP_BIT_D           9
`define OMP_BIT_A           8

////////////////////////////////////////////////////////////////////////////
// Reset values
`define OMP_RST_ACC         8'h00
`define OMP_RST_BANK        4'h0
`define OMP_RST_PTR         12'h000

////////////////////////////////////////////////////////////////////////////
// Opcodes and address map
`define OMP_OPC_IOR         6'h04
`define OMP_OPC_MOV         6'h14
`define OMP_OPC_COPY2       4'hC
`define OMP_OPC_SECOND      4'hF
`define OMP_OPC_PTR_LOAD    10'h3B8
`define OMP_PTR_LAST        2'h2
`define OMP_ACCESS_SPLIT    8'h60
`define OMP_ILO_MAX         8'h5F
`define OMP_SFR_PAGE        4'hF

`endif

// File: rtl/omp_pkg.sv
`include "omp_map.svh"

package omp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_Q1    = 3'b001,
        ST_Q2    = 3'b010,
        ST_Q3    = 3'b011,
        ST_Q4    = 3'b100,
        ST_WAIT2 = 3'b101
    } omp_state_e;

    typedef enum logic [2:0] {
        OP_NONE     = 3'b000,
        OP_IOR      = 3'b001,
        OP_MOV      = 3'b010,
        OP_PTR_LOAD = 3'b011,
        OP_COPY2    = 3'b100
    } omp_op_e;

    typedef struct packed {
        omp_state_e       st;
        omp_op_e          op;
        logic             second;
        logic [15:0]      ir;
        logic             dst;
        logic             indexed;
        logic [1:0]       psel;
        logic [7:0]       data;
        logic             fn_pend;
        logic             fz_pend;
        logic [7:0]       acc;
        logic [3:0]       bank_sel;
        logic             fn;
        logic             fz;
        logic             ext_en;
        logic [2:0][11:0] ptr;
        logic             rd_pend;
        logic             wr_pend;
        logic             bus_hit;
        logic [7:0]       bus_addr;
        logic             hready;
        logic             hresp;
        logic [31:0]      hrdata;
        logic [11:0]      mem_addr;
        logic [7:0]       mem_wdata;
        logic             mem_re;
        logic             mem_we;
    } omp_regs_s;

    // Used by first-word decode only; the second word is checked on its top nibble
    function automatic omp_op_e classify(input logic [15:0] w);
        omp_op_e o;
        o = OP_NONE;
        if (w[15:10] == `OMP_OPC_IOR) begin
            o = OP_IOR;
        end else if (w[15:10] == `OMP_OPC_MOV) begin
            o = OP_MOV;
        end else if (w[15:12] == `OMP_OPC_COPY2) begin
            o = OP_COPY2;
        end else if (w[15:6] == `OMP_OPC_PTR_LOAD &&
                     w[5:4] <= `OMP_PTR_LAST) begin
            o = OP_PTR_LOAD;
        end
        return o;
    endfunction

endpackage

// File: tb/omp_core_exec_asserts.sv
module omp_core_exec_asserts (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Data memory
    input wire logic [11:0] mem_addr,
    input wire logic        mem_re,
    input wire logic        mem_we
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_RD_WAIT: assert property (hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout) else $error("read without wait state");
    AST_WR_NO_WAIT: assert property (hsel && hready && htrans[1] && hwrite
        |=> hreadyout) else $error("write stalled");
    AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout)
        else $error("wait state too long");
    // Read data must not drift between read answers
    AST_RDATA_HOLD: assert property (hreadyout && $past(hreadyout)
        |-> $stable(hrdata)) else $error("read data changed");
    AST_RE_PULSE: assert property (mem_re |=> !mem_re)
        else $error("read strobe too long");
    AST_WE_PULSE: assert property (mem_we |=> !mem_we)
        else $error("write strobe too long");
    AST_RW_EXCL: assert property (!(mem_re && mem_we))
        else $error("read and write together");
    AST_RE_THEN_GAP: assert property (mem_re |=> !mem_we)
        else $error("write in process phase");
    AST_WB_ADDR: assert property (mem_we && $past(mem_re, 2)
        |-> mem_addr == $past(mem_addr, 2)) else $error("write back addr");

    ////////////////////////////////////////////////////////////////////////
    COV_RMW: cover property (mem_re ##2 mem_we);
    COV_RD: cover property (!hreadyout);
    COV_FF: cover property (mem_we && !$past(mem_re, 2));
endmodule

bind omp_core_exec omp_core_exec_asserts i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .mem_addr(mem_addr),
    .mem_re(mem_re), .mem_we(mem_we)
);

// File: tb/omp_core_exec_tb.sv
`include "omp_map.svh"

module omp_core_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [7:0]  mem_rdata = 8'h00;
    logic        hreadyout, hresp, mem_re, mem_we;
    logic [31:0] hrdata;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem [4096];
    int          bad_count = 0;
    int          checked = 0;
    int          cycles = 0;

    always #5 hclk = ~hclk;

    omp_core_exec i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_re(mem_re), .mem_we(mem_we), .mem_rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Memory: one cycle latency, junk when not read
    always @(posedge hclk) begin
        if (mem_we)
            mem[mem_addr] <= mem_wdata;
        mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic w, input logic [8:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {23'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rchk(input logic [8:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask

    // Busy poll bounded; a stuck core is a mismatch
    task automatic exec(input logic [15:0] w);
        logic [31:0] q;
        int          n;
        wr(`OMP_OFS_INSTR, {16'h0000, w});
        n = 0;
        do begin
            xfer(1'b0, `OMP_OFS_STATE, 32'h0000_0000, q);
            n++;
        end while (q[0] !== 1'b0 && n < 20);
        `CHK(q[0], 1'b0)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk(`OMP_OFS_ACC, 32'h0000_0000);
        rchk(`OMP_OFS_FLAGS, 32'h0000_0000);
        rchk(`OMP_OFS_STATE, 32'h0000_0000);
        wr(9'h100, 32'hFFFF_FFFF);
        rchk(9'h100, 32'h0000_0000);
        $display("t_reset done");
    endtask

    task automatic t_or();
        wr(`OMP_OFS_ACC, 32'h0000_0091);
        wr(`OMP_OFS_BANK, 32'h0000_0003);
        mem[12'h313] = 8'h13;
        exec(16'h1113);
        rchk(`OMP_OFS_ACC, 32'h0000_0093);
        rchk(`OMP_OFS_FLAGS, 32'h0000_0002);
        `CHK(mem[12'h313], 8'h13)
        wr(`OMP_OFS_ACC, 32'h0000_0005);
        mem[12'hF70] = 8'h40;
        exec(16'h1270);
        `CHK(mem[12'hF70], 8'h45)
        rchk(`OMP_OFS_ACC, 32'h0000_0005);
        rchk(`OMP_OFS_FLAGS, 32'h0000_0000);
        $display("t_or done");
    endtask

    task automatic t_copy();
        wr(`OMP_OFS_BANK, 32'h0000_000A);
        mem[12'hAFF] = 8'h00;
        exec(16'h51FF);
        rchk(`OMP_OFS_ACC, 32'h0000_0000);
        rchk(`OMP_OFS_FLAGS, 32'h0000_0001);
        mem[12'hA00] = 8'h80;
        exec(16'h5300);
        rchk(`OMP_OFS_FLAGS, 32'h0000_0002);
        `CHK(mem[12'hA00], 8'h80)
        $display("t_copy done");
    endtask

    task automatic t_ptr();
        logic [11:0] k;
        wr(`OMP_OFS_FLAGS, 32'h0000_0003);
        for (int f = 0; f < 3; f++) begin
            k = 12'h3AB + 12'(f) * 12'h444;
            exec({10'h3B8, 2'(f), k[11:8]});
            rchk(`OMP_OFS_STATE, 32'h0000_0002);
            rchk(9'(`OMP_OFS_PTR0 + 4 * f),
                 {20'h0, k[11:8], 8'h00});
            exec({8'hF0, k[7:0]});
            rchk(9'(`OMP_OFS_PTR0 + 4 * f), {20'h0, k});
        end
        rchk(`OMP_OFS_FLAGS, 32'h0000_0003);
        exec(16'hEE35);
        rchk(`OMP_OFS_STATE, 32'h0000_0000);
        rchk(`OMP_OFS_PTR0, 32'h0000_03AB);
        $display("t_ptr done");
    endtask

    task automatic t_ext();
        wr(`OMP_OFS_CTRL, 32'h0000_0001);
        wr(`OMP_OFS_PTR2, 32'h0000_0200);
        mem[12'h25F] = 8'h80;
        mem[12'hF60] = 8'h7E;
        exec(16'h505F);
        rchk(`OMP_OFS_ACC, 32'h0000_0080);
        rchk(`OMP_OFS_STATE, 32'h0000_0004);
        exec(16'h5060);
        rchk(`OMP_OFS_ACC, 32'h0000_007E);
        rchk(`OMP_OFS_STATE, 32'h0000_0000);
        wr(`OMP_OFS_CTRL, 32'h0000_0000);
        $display("t_ext done");
    endtask

    // Corner addresses both ends of the space
    task automatic t_far();
        wr(`OMP_OFS_FLAGS, 32'h0000_0002);
        mem[12'h000] = 8'h5A;
        mem[12'hFFF] = 8'h11;
        exec(16'hC000);
        `CHK(mem[12'hFFF], 8'h11)
        rchk(`OMP_OFS_STATE, 32'h0000_0002);
        exec(16'hFFFF);
        `CHK(mem[12'hFFF], 8'h5A)
        rchk(`OMP_OFS_FLAGS, 32'h0000_0002);
        $display("t_far done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_or();
        t_copy();
        t_ptr();
        t_ext();
        t_far();
        results();
    end
endmodule
